// ===== shared/smbrp_pkg.sv
// Purpose: Shared constants for the multiplexed bus and boot ROM port.
// Assumes: One clock, ref_clk at 100 MHz.
// Notes:   Lane bit 0 of each pin group is the most significant bit.
package smbrp_pkg;

  // ==========================================================
  // Widths
  localparam int LANE_W = 8;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 16;
  localparam int ROM_AW = 16;

  // ==========================================================
  // Timing counts in ref_clk cycles
  localparam int CLK_HALF_CYC = 2;   // Bus clock half period
  localparam int PHASE_CYC    = 2;   // Cycles each direct I/O lane phase holds
  localparam int ROM_ACC_CYC  = 4;   // ROM access time before sampling

  // ==========================================================
  // Reset values
  localparam logic RST_CLK_LEVEL = 1'b1;
  localparam logic RST_STROBE_N  = 1'b1;

  // ==========================================================
  // Cycle kinds
  typedef enum logic [1:0] {
    SMBRP_DIO_WR = 2'h0,
    SMBRP_DIO_RD = 2'h1,
    SMBRP_DMA_WR = 2'h2,
    SMBRP_DMA_RD = 2'h3
  } smbrp_kind_e;

  // Reverse a lane so pin index 0 is the MSB
  function automatic logic [LANE_W-1:0] smbrp_swap(
    input logic [LANE_W-1:0] v
  );
    logic [LANE_W-1:0] r;
    r = '0;
    for (int i = 0; i < LANE_W; i++) begin
      r[i] = v[LANE_W-1-i];
    end
    return r;
  endfunction

endpackage

// ===== shared/smbrp_if.sv
// Purpose: Pin bundle between the bridge end and the processor end.
// Assumes: Two-way pins resolve here from the enables; ROM not modelled.
// Notes:   Pulled-up strobe reads high when nobody drives it.
interface smbrp_if;
  import smbrp_pkg::*;

  // ==========================================================
  // Driven pieces
  logic              bus_clk;
  logic [LANE_W-1:0] hi_dev_o, hi_proc_o, lo_dev_o, lo_proc_o;
  logic              hi_dev_oe, hi_proc_oe, lo_dev_oe, lo_proc_oe;
  logic [LANE_W-1:0] lo_rom_o;
  logic              lo_rom_oe;
  logic              as_dev_o, as_dev_oe, as_proc_o, as_proc_oe;
  logic              latch_pulse;
  logic              bus_req_n, bus_gnt_n;
  logic              dio_sel_n, dio_rw;
  logic              xfer_ack_n;
  logic [LANE_W-1:0] rom_addr_low;
  logic              rom_oe_n;

  // ==========================================================
  // Resolved wire levels
  logic [LANE_W-1:0] high_byte_lane, low_byte_lane;
  logic              addr_strobe_n;
  assign high_byte_lane = hi_dev_oe ? hi_dev_o :
                          hi_proc_oe ? hi_proc_o : '1;
  assign low_byte_lane  = lo_dev_oe ? lo_dev_o :
                          lo_proc_oe ? lo_proc_o :
                          lo_rom_oe ? lo_rom_o : '1;
  assign addr_strobe_n  = as_dev_oe ? as_dev_o :
                          as_proc_oe ? as_proc_o : 1'b1;

  modport dev (
    output bus_clk, hi_dev_o, hi_dev_oe, lo_dev_o, lo_dev_oe,
    output as_dev_o, as_dev_oe, bus_gnt_n, dio_sel_n, dio_rw,
    output xfer_ack_n, rom_addr_low, rom_oe_n,
    input  high_byte_lane, low_byte_lane, addr_strobe_n,
    input  latch_pulse, bus_req_n
  );
  modport proc (
    output hi_proc_o, hi_proc_oe, lo_proc_o, lo_proc_oe,
    output as_proc_o, as_proc_oe, latch_pulse, bus_req_n,
    input  bus_clk, high_byte_lane, low_byte_lane, addr_strobe_n,
    input  bus_gnt_n, dio_sel_n, dio_rw, xfer_ack_n
  );
endinterface

// ===== src/smbrp_dev.sv
// Purpose: Bridge end: bus clock, direct I/O master, DMA slave, boot ROM.
// Assumes: Inputs synchronous to ref_clk; ROM data valid ROM_ACC_CYC on.
// Notes:   One owner of the lanes at a time; requests wait otherwise.
//
// Contract
// - Software may park bus clock high
// - Power-down holds bus clock high
// - High lane: addr 31-24/15-8, data 15-8
// - Low lane: addr 23-16/7-0, data 7-0
// - Address in two halves, 16-bit data
// - ROM access drives ROM address high byte
// - ROM data read on low lane, swapped
// - Latch pulse captures low 16 address bits
// - Strobe driven in direct I/O, input in DMA
// - Strobe low only while address valid; code holds it low in low address and data phases
// - Device supplies the bus clock
// - ROM low address on dedicated pins
// - ROM output enable only during ROM access
module smbrp_dev
  import smbrp_pkg::*;
#(
  parameter int HALF_CYC = CLK_HALF_CYC
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                reset,
  // Clock control
  input  wire logic                clk_park,
  input  wire logic                power_down,
  // Direct I/O request
  input  wire logic                dio_valid,
  output logic                     dio_ready,
  input  wire logic                dio_write,
  input  wire logic [ADDR_W-1:0]   dio_addr,
  input  wire logic [DATA_W-1:0]   dio_wdata,
  output logic                     dio_done,
  output logic [DATA_W-1:0]        dio_rdata,
  // Boot ROM request
  input  wire logic                rom_valid,
  output logic                     rom_ready,
  input  wire logic [ROM_AW-1:0]   rom_addr,
  output logic                     rom_done,
  output logic [LANE_W-1:0]        rom_rdata,
  // DMA word buffer out
  output logic                     dma_valid,
  input  wire logic                dma_ready,
  output logic [ADDR_W-1:0]        dma_addr,
  output logic [DATA_W-1:0]        dma_data,
  // Pins
  smbrp_if.dev                     pins
);

  // Refuse a half period the 8-bit divider cannot count
  if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_half_bad
    $error("HALF_CYC out of range");
  end

  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_AHI = 7'h02, S_ALO = 7'h04, S_DATA = 7'h08,
    S_ROM  = 7'h10, S_DMA = 7'h20, S_END = 7'h40
  } smbrp_st_e;

  smbrp_st_e        st;
  logic [7:0]       div_cnt;
  logic [7:0]       ph_cnt;
  logic             clk_q;
  logic [ADDR_W-1:0] a_q;
  logic [DATA_W-1:0] w_q;
  logic             wr_q;
  logic [15:0]      dma_lo;
  logic [ADDR_W-1:0] dma_hi;
  logic [1:0]       buf_cnt;
  logic [ADDR_W+DATA_W-1:0] buf0, buf1;
  logic             gnt;
  logic             dma_push;
  logic             as_prev;

  // ==========================================================
  // Bus clock divider, parked high on request or power-down
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div_cnt <= 8'h00;
      clk_q   <= RST_CLK_LEVEL;
    end else if (clk_park || power_down) begin
      div_cnt <= 8'h00;
      clk_q   <= 1'b1;
    end else if (div_cnt == 8'(HALF_CYC - 1)) begin
      div_cnt <= 8'h00;
      clk_q   <= ~clk_q;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end
  assign pins.bus_clk = clk_q;

  // ==========================================================
  // Lane owner sequencer
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st        <= S_IDLE;
      ph_cnt    <= 8'h00;
      a_q       <= '0;
      w_q       <= '0;
      wr_q      <= 1'b0;
      gnt       <= 1'b0;
      dio_done  <= 1'b0;
      dio_rdata <= '0;
      rom_done  <= 1'b0;
      rom_rdata <= '0;
    end else begin
      dio_done <= 1'b0;
      rom_done <= 1'b0;
      ph_cnt   <= ph_cnt + 8'h01;
      case (st)
        S_IDLE: begin
          ph_cnt <= 8'h00;
          if (!pins.bus_req_n && buf_cnt != 2'h2) begin
            gnt <= 1'b1;
            st  <= S_DMA;
          end else if (dio_valid && pins.bus_req_n) begin
            a_q  <= dio_addr;
            w_q  <= dio_wdata;
            wr_q <= dio_write;
            st   <= S_AHI;
          end else if (rom_valid && pins.bus_req_n) begin
            a_q <= {16'h0000, rom_addr};
            st  <= S_ROM;
          end
        end
        S_AHI: if (ph_cnt == 8'(PHASE_CYC - 1)) begin
          ph_cnt <= 8'h00;
          st     <= S_ALO;
        end
        S_ALO: if (ph_cnt == 8'(PHASE_CYC - 1)) begin
          ph_cnt <= 8'h00;
          st     <= S_DATA;
        end
        S_DATA: if (ph_cnt == 8'(PHASE_CYC - 1)) begin
          dio_rdata <= {smbrp_swap(pins.high_byte_lane),
                        smbrp_swap(pins.low_byte_lane)};
          dio_done  <= 1'b1;
          st        <= S_END;
        end
        S_ROM: if (ph_cnt == 8'(ROM_ACC_CYC - 1)) begin
          rom_rdata <= smbrp_swap(pins.low_byte_lane);
          rom_done  <= 1'b1;
          st        <= S_END;
        end
        S_DMA: if (pins.bus_req_n) begin
          gnt <= 1'b0;
          st  <= S_END;
        end
        S_END: st <= S_IDLE;
        default: st <= S_IDLE;
      endcase
    end
  end
  assign dio_ready = (st == S_IDLE) && pins.bus_req_n;
  assign rom_ready = (st == S_IDLE) && pins.bus_req_n && !dio_valid;

  // ==========================================================
  // Pin drive per state
  always_comb begin
    pins.hi_dev_o  = '0;
    pins.lo_dev_o  = '0;
    pins.hi_dev_oe = 1'b0;
    pins.lo_dev_oe = 1'b0;
    case (st)
      S_AHI: begin
        pins.hi_dev_o  = smbrp_swap(a_q[31:24]);
        pins.lo_dev_o  = smbrp_swap(a_q[23:16]);
        pins.hi_dev_oe = 1'b1;
        pins.lo_dev_oe = 1'b1;
      end
      S_ALO: begin
        pins.hi_dev_o  = smbrp_swap(a_q[15:8]);
        pins.lo_dev_o  = smbrp_swap(a_q[7:0]);
        pins.hi_dev_oe = 1'b1;
        pins.lo_dev_oe = 1'b1;
      end
      S_DATA: begin
        pins.hi_dev_o  = smbrp_swap(w_q[15:8]);
        pins.lo_dev_o  = smbrp_swap(w_q[7:0]);
        pins.hi_dev_oe = wr_q;
        pins.lo_dev_oe = wr_q;
      end
      S_ROM: begin
        pins.hi_dev_o  = smbrp_swap(a_q[15:8]);
        pins.hi_dev_oe = 1'b1;
      end
      default: begin
        pins.hi_dev_oe = 1'b0;
      end
    endcase
  end
  assign pins.rom_addr_low = (st == S_ROM) ? a_q[7:0] : 8'h00;
  assign pins.rom_oe_n     = (st != S_ROM);
  assign pins.as_dev_oe    = (st == S_ALO) || (st == S_DATA);
  assign pins.as_dev_o     = 1'b0;
  assign pins.dio_sel_n    = !((st == S_ALO) || (st == S_DATA));
  assign pins.dio_rw       = !wr_q;
  assign pins.bus_gnt_n    = !gnt;

  // ==========================================================
  // DMA high address half before the latch pulse, low half on it
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dma_lo  <= 16'h0000;
      dma_hi  <= '0;
      as_prev <= RST_STROBE_N;
    end else begin
      as_prev <= pins.addr_strobe_n;
      if (gnt && pins.latch_pulse) begin
        dma_lo <= {smbrp_swap(pins.high_byte_lane),
                   smbrp_swap(pins.low_byte_lane)};
      end
      if (gnt && !pins.latch_pulse && pins.addr_strobe_n && as_prev) begin
        dma_hi <= {smbrp_swap(pins.high_byte_lane),
                   smbrp_swap(pins.low_byte_lane), 16'h0000};
      end
    end
  end
  // Processor ends a DMA write by strobe low with data on the lanes
  assign dma_push = gnt && !pins.addr_strobe_n && as_prev;
  assign pins.xfer_ack_n = !(gnt && !pins.addr_strobe_n);

  // ==========================================================
  // Two-entry buffer for received DMA words
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      buf_cnt <= 2'h0;
      buf0    <= '0;
      buf1    <= '0;
    end else begin
      if (dma_valid && dma_ready) begin
        buf0 <= buf1;
      end
      if (dma_push && buf_cnt != 2'h2) begin
        if (buf_cnt == 2'h0 || (buf_cnt == 2'h1 && dma_ready)) begin
          buf0 <= {dma_hi[31:16], dma_lo, pins.high_byte_lane,
                   pins.low_byte_lane};
        end else begin
          buf1 <= {dma_hi[31:16], dma_lo, pins.high_byte_lane,
                   pins.low_byte_lane};
        end
      end
      buf_cnt <= buf_cnt
               + 2'((dma_push && buf_cnt != 2'h2) ? 1 : 0)
               - 2'((dma_valid && dma_ready) ? 1 : 0);
    end
  end
  assign dma_valid = (buf_cnt != 2'h0);
  assign dma_addr  = buf0[ADDR_W+DATA_W-1:DATA_W];
  assign dma_data  = {smbrp_swap(buf0[15:8]), smbrp_swap(buf0[7:0])};

endmodule

// ===== src/smbrp_proc.sv
// Purpose: Processor end: requests the bus and writes DMA words.
// Assumes: Bridge grants and acknowledges; one word per grant.
// Notes:   Address high half, then latch pulse with low half, then data.
module smbrp_proc
  import smbrp_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // DMA write request
  input  wire logic              wr_valid,
  output logic                   wr_ready,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  output logic                   wr_done,
  // Pins
  smbrp_if.proc                  pins
);

  typedef enum logic [5:0] {
    P_IDLE = 6'h01, P_REQ = 6'h02, P_AHI = 6'h04,
    P_ALO = 6'h08, P_DAT = 6'h10, P_REL = 6'h20
  } smbrp_pst_e;

  smbrp_pst_e        st;
  logic [ADDR_W-1:0] a_q;
  logic [DATA_W-1:0] d_q;

  // ==========================================================
  // DMA master sequence
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st      <= P_IDLE;
      a_q     <= '0;
      d_q     <= '0;
      wr_done <= 1'b0;
    end else begin
      wr_done <= 1'b0;
      case (st)
        P_IDLE: if (wr_valid) begin
          a_q <= wr_addr;
          d_q <= wr_data;
          st  <= P_REQ;
        end
        P_REQ: if (!pins.bus_gnt_n) begin
          st <= P_AHI;
        end
        P_AHI: st <= P_ALO;
        P_ALO: st <= P_DAT;
        P_DAT: if (!pins.xfer_ack_n) begin
          wr_done <= 1'b1;
          st      <= P_REL;
        end
        P_REL: if (pins.bus_gnt_n) begin
          st <= P_IDLE;
        end
        default: st <= P_IDLE;
      endcase
    end
  end
  assign wr_ready = (st == P_IDLE);

  // ==========================================================
  // Pin drive: high half, low half with pulse, then data with strobe
  assign pins.bus_req_n   = !((st == P_REQ) || (st == P_AHI) ||
                              (st == P_ALO) || (st == P_DAT));
  assign pins.latch_pulse = (st == P_ALO);
  assign pins.hi_proc_oe  = (st == P_AHI) || (st == P_ALO) ||
                            (st == P_DAT);
  assign pins.lo_proc_oe  = pins.hi_proc_oe;
  assign pins.hi_proc_o   = (st == P_AHI) ? smbrp_swap(a_q[31:24]) :
                            (st == P_ALO) ? smbrp_swap(a_q[15:8]) :
                            smbrp_swap(d_q[15:8]);
  assign pins.lo_proc_o   = (st == P_AHI) ? smbrp_swap(a_q[23:16]) :
                            (st == P_ALO) ? smbrp_swap(a_q[7:0]) :
                            smbrp_swap(d_q[7:0]);
  assign pins.as_proc_oe  = (st == P_DAT);
  assign pins.as_proc_o   = 1'b0;

endmodule

// ===== dv/smbrp_properties.sv
// Purpose: Pin-level checks between the bridge and processor ends.
// Assumes: One clock domain, reset active high.
// Notes:   Takes the interface signals as plain inputs.
module smbrp_properties #(
  parameter int HALF_CYC = 2
) (
  // Clock, reset and clock control
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       clk_park,
  input wire logic       power_down,
  // Pins and enables
  input wire logic       bus_clk,
  input wire logic [7:0] high_byte_lane,
  input wire logic [7:0] rom_addr_low,
  input wire logic       rom_oe_n,
  input wire logic       addr_strobe_n,
  input wire logic       latch_pulse,
  input wire logic       bus_gnt_n,
  input wire logic       dio_sel_n,
  input wire logic       hi_dev_oe,
  input wire logic       hi_proc_oe,
  input wire logic       lo_dev_oe,
  input wire logic       lo_proc_oe,
  input wire logic       as_dev_oe,
  input wire logic       as_proc_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ==========================================================
  // Bus clock
  a_park_clk_high: assert property (clk_park ##1 clk_park |-> bus_clk)
    else $error("bus clock not parked high");
  a_pdown_clk_high: assert property (power_down ##1 power_down |-> bus_clk)
    else $error("bus clock not high in power down");
  a_clk_runs: assert property ((!clk_park && !power_down)[*6] |->
    bus_clk != $past(bus_clk, HALF_CYC))
    else $error("bus clock not toggling");

  // ==========================================================
  // Boot ROM sharing
  a_rom_oe_len: assert property ($fell(rom_oe_n) |-> !rom_oe_n[*4] ##1 rom_oe_n)
    else $error("ROM enable length wrong");
  a_rom_excl: assert property (!rom_oe_n |-> dio_sel_n && bus_gnt_n &&
    !hi_proc_oe && !lo_proc_oe && !lo_dev_oe)
    else $error("ROM access overlaps bus cycle");
  a_rom_pins_hold: assert property (!rom_oe_n && !$past(rom_oe_n) |->
    $stable(high_byte_lane) && $stable(rom_addr_low) && hi_dev_oe)
    else $error("ROM address moved during access");

  // ==========================================================
  // Lanes and strobe
  a_lane_no_clash: assert property (!(hi_dev_oe && hi_proc_oe) &&
    !(lo_dev_oe && lo_proc_oe))
    else $error("two drivers on a lane");
  a_strobe_dma_in: assert property (!bus_gnt_n |-> !as_dev_oe)
    else $error("bridge drives strobe during DMA");
  a_strobe_dio_out: assert property (!addr_strobe_n && !as_proc_oe |->
    as_dev_oe && !dio_sel_n)
    else $error("strobe low outside a transfer");
  a_latch_in_dma: assert property (latch_pulse |-> !bus_gnt_n)
    else $error("latch pulse without grant");
endmodule

// ===== dv/tb_sif_mux_bus_rom_port.sv
// Purpose: Self-checking bench joining the bridge and processor ends.
// Assumes: ROM model here answers from its address pins.
// Notes:   Lane pin 0 is the MSB, so expectations reverse bytes.
module tb_sif_mux_bus_rom_port
  import smbrp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              ref_clk, reset, clk_park, power_down;
  logic              dio_valid, dio_ready, dio_write, dio_done;
  logic              rom_valid, rom_ready, rom_done, dma_valid, dma_ready;
  logic              wr_valid, wr_ready, wr_done;
  logic [ADDR_W-1:0] dio_addr, dma_addr, wr_addr;
  logic [DATA_W-1:0] dio_wdata, dio_rdata, dma_data, wr_data;
  logic [ROM_AW-1:0] rom_addr;
  logic [LANE_W-1:0] rom_rdata, mon_hi, mon_lo;
  logic [47:0]       exp_q[$];
  int                fail_count, comparisons, rdy_mode;

  smbrp_if pins ();
  smbrp_dev #(.HALF_CYC(CLK_HALF_CYC)) smbrp_dev_i (.ref_clk(ref_clk),
    .reset(reset), .clk_park(clk_park), .power_down(power_down),
    .dio_valid(dio_valid), .dio_ready(dio_ready), .dio_write(dio_write),
    .dio_addr(dio_addr), .dio_wdata(dio_wdata), .dio_done(dio_done),
    .dio_rdata(dio_rdata), .rom_valid(rom_valid), .rom_ready(rom_ready),
    .rom_addr(rom_addr), .rom_done(rom_done), .rom_rdata(rom_rdata),
    .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_addr(dma_addr),
    .dma_data(dma_data), .pins(pins));
  smbrp_proc smbrp_proc_i (.ref_clk(ref_clk), .reset(reset),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_done(wr_done), .pins(pins));
  smbrp_properties #(.HALF_CYC(CLK_HALF_CYC)) smbrp_properties_i (
    .ref_clk(ref_clk), .reset(reset), .clk_park(clk_park),
    .power_down(power_down), .bus_clk(pins.bus_clk),
    .high_byte_lane(pins.high_byte_lane), .rom_addr_low(pins.rom_addr_low),
    .rom_oe_n(pins.rom_oe_n), .addr_strobe_n(pins.addr_strobe_n),
    .latch_pulse(pins.latch_pulse), .bus_gnt_n(pins.bus_gnt_n),
    .dio_sel_n(pins.dio_sel_n), .hi_dev_oe(pins.hi_dev_oe),
    .hi_proc_oe(pins.hi_proc_oe), .lo_dev_oe(pins.lo_dev_oe),
    .lo_proc_oe(pins.lo_proc_oe), .as_dev_oe(pins.as_dev_oe),
    .as_proc_oe(pins.as_proc_oe));

  // ==========================================================
  // Helpers
  function automatic logic [7:0] rv(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rv[i] = v[7-i];
  endfunction
  function automatic logic [7:0] rom_val(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h5A;
  endfunction

  // Boot ROM model, data bit 7 on lane pin 0
  assign pins.lo_rom_oe = ~pins.rom_oe_n;
  assign pins.lo_rom_o  = rv(rom_val({rv(pins.high_byte_lane),
                                      pins.rom_addr_low}));

  // Lane values of the previous cycle; receiver ready pattern
  always @(posedge ref_clk) begin
    mon_hi    <= pins.high_byte_lane;
    mon_lo    <= pins.low_byte_lane;
    dma_ready <= (rdy_mode == 2) ? 1'($urandom_range(0, 1)) : rdy_mode[0];
  end
  // Buffered words leave in order
  always @(posedge ref_clk) begin
    if (!reset && dma_valid === 1'b1 && dma_ready === 1'b1) begin
      chk_buf({dma_addr, dma_data}, exp_q.pop_front());
    end
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_buf(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits at falling edges, bounded
  task automatic wait_lvl(ref logic s, input logic v);
    for (int n = 0; n < 40 && s !== v; n++) @(negedge ref_clk);
    chk_val(32'(s), 32'(v));
  endtask

  // ==========================================================
  // Transfers
  task automatic dio_op(input logic w, input logic [31:0] a,
                        input logic [15:0] d);
    @(posedge ref_clk);
    dio_valid <= 1'b1;
    dio_write <= w;
    dio_addr  <= a;
    dio_wdata <= d;
    @(posedge ref_clk);
    for (int n = 0; n < 40 && dio_ready !== 1'b1; n++) @(posedge ref_clk);
    dio_valid <= 1'b0;
    @(negedge ref_clk);
    wait_lvl(pins.dio_sel_n, 1'b0);
    chk_val({mon_hi, mon_lo}, {rv(a[31:24]), rv(a[23:16])});
    chk_val({pins.high_byte_lane, pins.low_byte_lane},
            {rv(a[15:8]), rv(a[7:0])});
    chk_val(32'(pins.addr_strobe_n), 32'h0);
    repeat (2) @(negedge ref_clk);
    if (w) chk_val({pins.high_byte_lane, pins.low_byte_lane},
                   {rv(d[15:8]), rv(d[7:0])});
    wait_lvl(dio_done, 1'b1);
    if (!w) chk_val(dio_rdata, {rv(mon_hi), rv(mon_lo)});
  endtask

  task automatic rom_op(input logic [15:0] a);
    @(posedge ref_clk);
    rom_valid <= 1'b1;
    rom_addr  <= a;
    @(posedge ref_clk);
    for (int n = 0; n < 40 && rom_ready !== 1'b1; n++) @(posedge ref_clk);
    rom_valid <= 1'b0;
    @(negedge ref_clk);
    wait_lvl(pins.rom_oe_n, 1'b0);
    chk_val(pins.high_byte_lane, rv(a[15:8]));
    chk_val(pins.rom_addr_low, a[7:0]);
    wait_lvl(rom_done, 1'b1);
    chk_val(rom_rdata, rom_val(a));
    chk_val(32'(pins.rom_oe_n), 32'h1);
  endtask

  task automatic dma_wr(input logic [31:0] a, input logic [15:0] d,
                        input logic stall);
    @(posedge ref_clk);
    wr_valid <= 1'b1;
    wr_addr  <= a;
    wr_data  <= d;
    @(posedge ref_clk);
    for (int n = 0; n < 40 && wr_ready !== 1'b1; n++) @(posedge ref_clk);
    wr_valid <= 1'b0;
    exp_q.push_back({a, d});
    if (!stall) begin
      @(negedge ref_clk);
      wait_lvl(pins.latch_pulse, 1'b1);
      chk_val({mon_hi, mon_lo}, {rv(a[31:24]), rv(a[23:16])});
      chk_val({pins.high_byte_lane, pins.low_byte_lane},
              {rv(a[15:8]), rv(a[7:0])});
      wait_lvl(pins.addr_strobe_n, 1'b0);
      chk_val({pins.high_byte_lane, pins.low_byte_lane},
              {rv(d[15:8]), rv(d[7:0])});
      wait_lvl(wr_done, 1'b1);
    end
  endtask

  task automatic complete_run;
    $display("Compares %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #100us;
    fail_count++;
    complete_run();
  end
  initial begin
    int c;
    logic p;
    {reset, clk_park, power_down, dio_valid, dio_write} = 5'h10;
    {rom_valid, wr_valid} = 2'h0;
    {dio_addr, wr_addr, dio_wdata, wr_data, rom_addr} = '0;
    {fail_count, comparisons, rdy_mode} = {32'h0, 32'h0, 32'h1};
    void'($urandom(98824));
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    clk_park <= 1'b1;
    repeat (6) begin
      @(negedge ref_clk);
      chk_val(32'(pins.bus_clk), 32'h1);
    end
    @(posedge ref_clk);
    clk_park   <= 1'b0;
    power_down <= 1'b1;
    repeat (6) begin
      @(negedge ref_clk);
      chk_val(32'(pins.bus_clk), 32'h1);
    end
    @(posedge ref_clk);
    power_down <= 1'b0;
    repeat (8) @(negedge ref_clk);
    c = 0;
    p = pins.bus_clk;
    repeat (16) begin
      @(negedge ref_clk);
      if (pins.bus_clk !== p) c++;
      p = pins.bus_clk;
    end
    chk_val(c, 16 / CLK_HALF_CYC);
    dio_op(1'b1, 32'hFFFFFFFF, 16'h0000);
    dio_op(1'b0, 32'h00000000, 16'hFFFF);
    repeat (6) dio_op(1'($urandom), $urandom, 16'($urandom));
    rom_op(16'h0000);
    rom_op(16'hFFFF);
    repeat (4) rom_op(16'($urandom));
    fork
      dio_op(1'b1, $urandom, 16'($urandom));
      rom_op(16'($urandom));
    join
    rdy_mode = 2;
    repeat (4) dma_wr($urandom, 16'($urandom), 1'b0);
    // Drain fully so the stall case starts from an empty buffer
    rdy_mode = 1;
    repeat (20) @(posedge ref_clk);
    rdy_mode = 0;
    repeat (2) dma_wr($urandom, 16'($urandom), 1'b0);
    dma_wr(32'hA5A5_0F0F, 16'h8001, 1'b1);
    repeat (20) @(negedge ref_clk);
    chk_val({31'h0, dma_valid}, 32'h1);
    chk_val(exp_q.size(), 3);
    rdy_mode = 1;
    for (int n = 0; n < 80 && exp_q.size() != 0; n++) @(posedge ref_clk);
    chk_val(exp_q.size(), 0);
    complete_run();
  end
endmodule
